/* File: design/csm_consts.vh */
`ifndef CSM_CONSTS_VH
`define CSM_CONSTS_VH

// ----------------------------------------------------------------------
// Register locations
// ----------------------------------------------------------------------
`define CSM_ADDR_BATT_SENSE   8'h08
`define CSM_ADDR_TEMP_SENSE   8'h09
`define CSM_ADDR_STAT_MASK    8'h0A
`define CSM_ADDR_CHG1_MASK    8'h0B
`define CSM_ADDR_CHG2_MASK    8'h0C

// ----------------------------------------------------------------------
// Writable bit sets and reset values
// ----------------------------------------------------------------------
`define CSM_STAT_THERM_BITS   8'h3C
`define CSM_STAT_BUS_BITS     8'h01
`define CSM_CHG1_BITS         8'h1B
`define CSM_CHG2_BITS         8'h0E
`define CSM_STAT_RESET        8'h00
`define CSM_CHG1_RESET        8'h00
`define CSM_CHG2_RESET        8'h0E

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CSM_B_OVP             6
`define CSM_B_RECHG           5
`define CSM_B_WEAK            4
`define CSM_B_PRE             3
`define CSM_B_SAFE            2
`define CSM_B_IEND            1
`define CSM_T_SHUT            3
`define CSM_T_SECOND          2
`define CSM_T_FIRST           1
`define CSM_T_WARN            0
`define CSM_M_WARN            5
`define CSM_M_FIRST           4
`define CSM_M_SECOND          3
`define CSM_M_SHUT            2
`define CSM_M_BUS             0
`define CSM_M_INLO            4
`define CSM_M_INHI            3
`define CSM_M_BUCK            1
`define CSM_M_STATE           0
`define CSM_M_WDOG            3
`define CSM_M_USB             2
`define CSM_M_CHGTO           1

`endif

/* File: design/csm_regs.v */
`timescale 1ns/100ps
`include "csm_consts.vh"

// How it works
// - Battery sense bit 6 at 08 reads the live battery over-voltage comparator.
// - Battery sense bits 5, 4, 3 and 2 read the recharge, weak, precharge and safe comparators.
// - Battery sense bit 1 reads 1 while charge current exceeds the end-of-charge level.
// - Temperature sense bit 3 at 09 reads the live thermal shutdown comparator.
// - Temperature sense bits 2 and 1 read the second and first thermal comparators.
// - Temperature sense bit 0 reads the thermal warning comparator.
// - Status mask at 0A holds writable bits 5 to 2 for warning, first, second, shutdown, reset 0.
// - Status mask bit 0 masks input-bus-valid and clears also on host supply mode entry.
// - Charger mask one at 0B holds input-low, input-high and buck masks at bits 4, 3, 1.
// - Charger mask one bit 0 masks state transitions and clears on every reset event.
// - Charger mask two holds watchdog and usb timeout masks at bits 3 and 2, reset to 1.
// - Status mask bits 5 to 2 keep their value across host supply mode entry.
// - The watchdog timeout flag is raised by the expiry of the 32 s watchdog timer.
module csm_regs (
  input  wire       clk_sys,
  input  wire       arst_n,
  input  wire       off_state,
  input  wire       reg_reset,
  input  wire       bus_host_supply_mode,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [7:0] addr,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  input  wire       battery_overvoltage_live,
  input  wire       recharge_level_live,
  input  wire       weak_charge_level_live,
  input  wire       precharge_level_live,
  input  wire       safe_level_live,
  input  wire       end_current_live,
  input  wire       thermal_shutdown_live,
  input  wire       thermal_second_live,
  input  wire       thermal_first_live,
  input  wire       thermal_warning_live,
  input  wire [7:0] status_flags,
  input  wire [7:0] charger_flags_one,
  input  wire [7:0] charger_flags_two,
  output wire       irq_out
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // A strobe only acts on the register whose location it names.
  function csm_hit;
    input       en;
    input [7:0] loc_sel;
    input [7:0] loc;
    begin
      csm_hit = en & (loc_sel == loc);
    end
  endfunction

  // Reserved positions are dropped here, so they can never read back as 1.
  function [7:0] csm_keep;
    input [7:0] value;
    input [7:0] bits;
    begin
      csm_keep = value & bits;
    end
  endfunction

  // --------------------------------------------------------------------
  // Comparator synchronisers
  // --------------------------------------------------------------------
  // Comparators are asynchronous to clk_sys, so each passes two stages.
  reg  [9:0] sense_meta_reg;
  reg  [9:0] sense_sync_reg;
  wire [9:0] sense_raw;
  reg        mode_meta_reg;
  reg        mode_sync_reg;
  reg        mode_prev_reg;
  wire       mode_entry;

  assign sense_raw = {thermal_warning_live, thermal_first_live, thermal_second_live,
                      thermal_shutdown_live, end_current_live, safe_level_live,
                      precharge_level_live, weak_charge_level_live,
                      recharge_level_live, battery_overvoltage_live};

  // No reset on the sense path: it only mirrors the comparators.
  always @(posedge clk_sys) begin
    sense_meta_reg <= sense_raw;
    sense_sync_reg <= sense_meta_reg;
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_meta_reg <= 1'b0;
      mode_sync_reg <= 1'b0;
      mode_prev_reg <= 1'b0;
    end else begin
      mode_meta_reg <= bus_host_supply_mode;
      mode_sync_reg <= mode_meta_reg;
      mode_prev_reg <= mode_sync_reg;
    end
  end

  assign mode_entry = mode_sync_reg & ~mode_prev_reg;

  // --------------------------------------------------------------------
  // Sense register images
  // --------------------------------------------------------------------
  wire [7:0] batt_sense;
  wire [7:0] temp_sense;

  assign batt_sense = {1'b0,
                       sense_sync_reg[0],
                       sense_sync_reg[1],
                       sense_sync_reg[2],
                       sense_sync_reg[3],
                       sense_sync_reg[4],
                       sense_sync_reg[5],
                       1'b0};
  assign temp_sense = {4'h0,
                       sense_sync_reg[6],
                       sense_sync_reg[7],
                       sense_sync_reg[8],
                       sense_sync_reg[9]};

  // --------------------------------------------------------------------
  // Mask registers
  // --------------------------------------------------------------------
  reg  [7:0] stat_mask_reg;
  reg  [7:0] stat_mask_next;
  reg  [7:0] chg1_mask_reg;
  reg  [7:0] chg1_mask_next;
  reg  [7:0] chg2_mask_reg;
  reg  [7:0] chg2_mask_next;
  wire       full_clear;

  localparam [7:0] stat_write_bits = `CSM_STAT_THERM_BITS | `CSM_STAT_BUS_BITS;

  // Off state and register reset act synchronously, like a soft reset.
  assign full_clear = off_state | reg_reset;

  // A clear beats a mode entry and a write in the same cycle, so a host cannot undo a reset by writing into it.
  // A mode entry beats a write in the same cycle, except on status mask bits 5 to 2, which keep the written value.
  always @* begin
    stat_mask_next = stat_mask_reg;
    chg1_mask_next = chg1_mask_reg;
    chg2_mask_next = chg2_mask_reg;
    if (csm_hit(wr_en, addr, `CSM_ADDR_STAT_MASK)) begin
      stat_mask_next = csm_keep(wr_data, stat_write_bits);
    end
    if (csm_hit(wr_en, addr, `CSM_ADDR_CHG1_MASK)) begin
      chg1_mask_next = csm_keep(wr_data, `CSM_CHG1_BITS);
    end
    if (csm_hit(wr_en, addr, `CSM_ADDR_CHG2_MASK)) begin
      chg2_mask_next = csm_keep(wr_data, `CSM_CHG2_BITS);
    end
    if (mode_entry) begin
      // Thermal masks survive the mode change, the rest fall back.
      stat_mask_next = (stat_mask_next & `CSM_STAT_THERM_BITS) | `CSM_STAT_RESET;
      chg1_mask_next = `CSM_CHG1_RESET;
      chg2_mask_next = `CSM_CHG2_RESET;
    end
    if (full_clear) begin
      stat_mask_next = `CSM_STAT_RESET;
      chg1_mask_next = `CSM_CHG1_RESET;
      chg2_mask_next = `CSM_CHG2_RESET;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stat_mask_reg <= `CSM_STAT_RESET;
      chg1_mask_reg <= `CSM_CHG1_RESET;
      chg2_mask_reg <= `CSM_CHG2_RESET;
    end else begin
      stat_mask_reg <= stat_mask_next;
      chg1_mask_reg <= chg1_mask_next;
      chg2_mask_reg <= chg2_mask_next;
    end
  end

  // --------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------
  // Read data is registered and holds until the next read strobe.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `CSM_ADDR_BATT_SENSE: rd_data <= batt_sense;
        `CSM_ADDR_TEMP_SENSE: rd_data <= temp_sense;
        `CSM_ADDR_STAT_MASK:  rd_data <= stat_mask_reg;
        `CSM_ADDR_CHG1_MASK:  rd_data <= chg1_mask_reg;
        `CSM_ADDR_CHG2_MASK:  rd_data <= chg2_mask_reg;
        default:              rd_data <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Interrupt gating
  // --------------------------------------------------------------------
  // Flags are kept by the flag bank; only their route to the pin is gated.
  // Bit 3 of the second flag group is the 32 s watchdog expiry.
  wire [7:0] stat_live;
  wire [7:0] chg1_live;
  wire [7:0] chg2_live;
  reg        irq_reg;

  assign stat_live = csm_keep(status_flags & ~stat_mask_reg, stat_write_bits);
  assign chg1_live = csm_keep(charger_flags_one & ~chg1_mask_reg, `CSM_CHG1_BITS);
  assign chg2_live = csm_keep(charger_flags_two & ~chg2_mask_reg, `CSM_CHG2_BITS);

  // Registered so the pin never shows a glitch while a flag and its mask move together.
  // The price is one cycle of latency between a flag and the pin.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |{stat_live, chg1_live, chg2_live};
    end
  end

  assign irq_out = irq_reg;

endmodule

/* File: tb/csm_regs_assertions.sv */
`timescale 1ns/100ps
// ----
// Port checks.
// ----
module csm_regs_chk (
  input wire       clk_sys,
  input wire       arst_n,
  input wire       off_state,
  input wire       reg_reset,
  input wire       wr_en,
  input wire       rd_en,
  input wire       irq_out,
  input wire       battery_overvoltage_live,
  input wire       thermal_shutdown_live,
  input wire [7:0] addr,
  input wire [7:0] rd_data,
  input wire [7:0] status_flags,
  input wire [7:0] charger_flags_one,
  input wire [7:0] charger_flags_two
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_unmapped_zero: assert property (
    rd_en && (addr < 8'h08 || addr > 8'h0C) |=> rd_data == 8'h00) else $error("unmapped read");
  a_temp_reserved: assert property (
    rd_en && addr == 8'h09 |=> rd_data[7:4] == 4'h0) else $error("reserved bits set");
  a_overvolt_sense: assert property (
    battery_overvoltage_live [*4] ##0 (rd_en && addr == 8'h08) |=> rd_data[6])
    else $error("overvoltage bit lost");
  a_shutdown_sense: assert property (
    !thermal_shutdown_live [*4] ##0 (rd_en && addr == 8'h09) |=> !rd_data[3])
    else $error("shutdown bit stuck");
  a_off_clears: assert property (
    off_state ##1 (rd_en && addr == 8'h0A) |=> rd_data == 8'h00) else $error("mask kept");
  a_mask_two_reset: assert property (
    reg_reset ##1 (rd_en && addr == 8'h0C) |=> rd_data == 8'h0E) else $error("bad reset");
  a_read_holds: assert property (!rd_en |=> $stable(rd_data)) else $error("read data moved");
  a_irq_idle: assert property (
    (status_flags | charger_flags_one | charger_flags_two) == 8'h00 |=> !irq_out)
    else $error("irq without flag");
  a_irq_unmasked: assert property (
    reg_reset ##1 status_flags[0] |=> irq_out) else $error("irq missing");
endmodule
bind csm_regs csm_regs_chk i_csm_regs_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .off_state(off_state), .reg_reset(reg_reset), .wr_en(wr_en), .rd_en(rd_en),
  .irq_out(irq_out), .battery_overvoltage_live(battery_overvoltage_live),
  .thermal_shutdown_live(thermal_shutdown_live), .addr(addr), .rd_data(rd_data),
  .status_flags(status_flags), .charger_flags_one(charger_flags_one),
  .charger_flags_two(charger_flags_two));

/* File: tb/csm_host.sv */
`timescale 1ns/100ps
// ----
// Host side of the register port.
// ----
module csm_host (
  input  wire       clk_sys,
  input  wire [7:0] rd_data,
  output reg        wr_en,
  output reg        rd_en,
  output reg  [7:0] addr,
  output reg  [7:0] wr_data
);
  initial begin
    {wr_en, rd_en, addr, wr_data} = 18'h0;
  end
  // Idle address and data are inverted so a stale value can never pass for a valid one.
  task xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk_sys);
    {wr_en, rd_en, addr, wr_data} = {w, !w, a, d};
    @(negedge clk_sys);
    {wr_en, rd_en, addr, wr_data} = {2'b00, ~a, ~d};
    q = rd_data;
  endtask
endmodule

/* File: tb/tb_csm_regs.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb_csm_regs;
  logic       clk_sys = 0, arst_n = 0, off_state = 0, reg_reset = 0, mode = 0;
  logic       wr_en, rd_en, irq_out;
  logic [9:0] live = 0;
  logic [7:0] sf = 0, f1 = 0, f2 = 0, rd_data, addr, wr_data, q;
  int         errors = 0, tests_run = 0;
  csm_host i_csm_host (.clk_sys(clk_sys), .rd_data(rd_data), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data));
  csm_regs i_csm_regs (.clk_sys(clk_sys), .arst_n(arst_n), .off_state(off_state),
    .reg_reset(reg_reset), .bus_host_supply_mode(mode), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .battery_overvoltage_live(live[9]),
    .recharge_level_live(live[8]), .weak_charge_level_live(live[7]),
    .precharge_level_live(live[6]), .safe_level_live(live[5]), .end_current_live(live[4]),
    .thermal_shutdown_live(live[3]), .thermal_second_live(live[2]),
    .thermal_first_live(live[1]), .thermal_warning_live(live[0]), .status_flags(sf),
    .charger_flags_one(f1), .charger_flags_two(f2), .irq_out(irq_out));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task wr(input logic [7:0] a, d);
    i_csm_host.xfer(1'b1, a, d, q);
  endtask
  task rdc(input logic [7:0] a, e);
    i_csm_host.xfer(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask
  task wr3(input logic [7:0] d);
    wr(8'h0A, d); wr(8'h0B, d); wr(8'h0C, d);
  endtask
  task rd3(input logic [7:0] a, b, c);
    rdc(8'h0A, a); rdc(8'h0B, b); rdc(8'h0C, c);
  endtask
  task t_sense;
    logic [9:0] p[4];
    p = '{10'h3FF, 10'h000, 10'h2AA, 10'h155};
    foreach (p[i]) begin
      live = p[i];
      repeat (4) @(negedge clk_sys);
      rdc(8'h08, {1'b0, p[i][9:4], 1'b0});
      rdc(8'h09, {4'h0, p[i][3:0]});
    end
    $display("sense test done");
  endtask
  task t_masks;
    wr3(8'hFF);
    rd3(8'h3D, 8'h1B, 8'h0E);
    wr3(8'h00);
    rd3(8'h00, 8'h00, 8'h00);
    wr(8'h08, 8'hFF);
    rdc(8'h08, 8'h2A);
    rdc(8'h3F, 8'h00);
    $display("mask test done");
  endtask
  task t_mode;
    wr3(8'hFF);
    mode = 1;
    repeat (4) @(negedge clk_sys);
    rd3(8'h3C, 8'h00, 8'h0E);
    mode = 0;
    $display("mode test done");
  endtask
  task t_clear;
    for (int i = 0; i < 2; i++) begin
      wr3(8'hFF);
      {reg_reset, off_state} = i ? 2'b10 : 2'b01;
      rdc(i ? 8'h0C : 8'h0A, i ? 8'h0E : 8'h00);
      {reg_reset, off_state} = 2'b00;
      rd3(8'h00, 8'h00, 8'h0E);
    end
    $display("clear test done");
  endtask
  task t_reset;
    live = 10'h3FF;
    wr3(8'hFF);
    arst_n = 0;
    @(negedge clk_sys);
    arst_n = 1;
    rd3(8'h00, 8'h00, 8'h0E);
    rdc(8'h08, 8'h7E);
    rdc(8'h09, 8'h0F);
    $display("reset test done");
  endtask
  task t_irq;
    reg_reset = 1'b1;
    @(negedge clk_sys);
    {reg_reset, sf} = {1'b0, 8'h05};
    @(negedge clk_sys);
    `CHK(irq_out, 1'b1)
    wr(8'h0A, 8'h05);
    @(negedge clk_sys);
    `CHK(irq_out, 1'b0)
    {sf, f2} = {8'h00, 8'h08};
    @(negedge clk_sys);
    `CHK(irq_out, 1'b0)
    wr(8'h0C, 8'h00);
    @(negedge clk_sys);
    `CHK(irq_out, 1'b1)
    f2 = 8'h00;
    $display("irq test done");
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    arst_n = 1;
    t_sense; t_masks; t_mode; t_clear; t_reset; t_irq;
    finish_test;
  end
  // The whole run takes under 150 cycles, so this limit is generous.
  initial begin
    #100us;
    errors++;
    finish_test;
  end
endmodule
